//--- core/tcc_pkg.sv
// Constants, field layout and register map of the 16-bit capture/compare timer.
// Assumes a single 100 MHz clock and a plain strobe-based register port.
//
// Notes on behaviour
// - Free-running mode counts up every count clock.
// - Past FFFFH set overflow, wrap, keep counting.
// - Overflow flag stays set until software clears.
// - Compare match on A raises irq A.
// - Compare match on B raises irq B.
// - A captures on reverse trigger A or B.
// - B captures only on trigger A edge.
// - Reverse-phase capture into A raises no irq.
// - Reverse mode: trigger B edge raises irq A only.
// - Clear-start: trigger A captures B, clears, toggles.
// - Clear-start: trigger B still captures into A.
// - Reverse plus falling: A on rise, B on fall.
// - Free-run compares toggle output on each match.
// - Free-run captures toggle only via trigger bit.
// - Trigger B alone never captures into B.
// - Edge select 11 means both edges.
// - Counter reads never disturb counting.
// - Edge select 01 rising, 10 prohibited.
// - Clear-start without trigger overflows and continues.
// - Run mode 00 stops and zeroes counter.

package tcc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, word addresses on the register port
  localparam int TCC_ADDR_W = 3;
  localparam logic [2:0] TCC_ADDR_COUNTER = 3'h0;
  localparam logic [2:0] TCC_ADDR_CC_A = 3'h1;
  localparam logic [2:0] TCC_ADDR_CC_B = 3'h2;
  localparam logic [2:0] TCC_ADDR_MODE = 3'h3;
  localparam logic [2:0] TCC_ADDR_CAPSEL = 3'h4;
  localparam logic [2:0] TCC_ADDR_PRESC = 3'h5;
  localparam logic [2:0] TCC_ADDR_OUTCTL = 3'h6;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int TCC_MODE_OVF_BIT = 0;
  localparam int TCC_MODE_TOGGLE_BIT = 1;
  localparam int TCC_MODE_RUN_LO = 2;
  localparam int TCC_CAPSEL_A_CAP_BIT = 0;
  localparam int TCC_CAPSEL_REVERSE_BIT = 1;
  localparam int TCC_CAPSEL_B_CAP_BIT = 2;
  localparam int TCC_PRESC_CLK_LO = 0;
  localparam int TCC_PRESC_A_EDGE_LO = 3;
  localparam int TCC_PRESC_B_EDGE_LO = 5;
  localparam int TCC_OUTCTL_ENABLE_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and counter top
  localparam logic [15:0] TCC_RST_COUNT = 16'h0000;
  localparam logic [15:0] TCC_RST_CC = 16'h0000;
  localparam logic [6:0] TCC_RST_PRESC = 7'h00;
  localparam logic [2:0] TCC_RST_CAPSEL = 3'h0;
  localparam logic [15:0] TCC_COUNT_MAX = 16'hFFFF;

  ////////////////////////////////////////////////////////////////////////////
  // Run modes, trigger edge encodings and count clock choices
  typedef enum logic [1:0] {
    TCC_RUN_STOP = 2'h0,
    TCC_RUN_FREE = 2'h1,
    TCC_RUN_CLEAR_START = 2'h2,
    TCC_RUN_RESERVED = 2'h3
  } tcc_run_mode_type;

  localparam logic [1:0] TCC_EDGE_FALL = 2'h0;
  localparam logic [1:0] TCC_EDGE_RISE = 2'h1;
  localparam logic [1:0] TCC_EDGE_BOTH = 2'h3;
  localparam logic [1:0] TCC_CLK_DIV1 = 2'h0;
  localparam logic [1:0] TCC_CLK_DIV4 = 2'h1;
  localparam logic [1:0] TCC_CLK_DIV16 = 2'h2;
  localparam logic [1:0] TCC_CLK_TRIG_A = 2'h3;
  localparam int TCC_PRESC_W = 4;
  localparam logic [3:0] TCC_DIV4_LAST = 4'h3;
  localparam logic [3:0] TCC_DIV16_LAST = 4'hF;

endpackage : tcc_pkg

//--- core/tcc_timer.sv
// 16-bit up-counter with two capture/compare registers, free-running and
// clear-and-start modes, trigger edge detection and a toggling output.
// Assumes trigger inputs already synchronous to ref_clk and a register
// master that issues single-cycle strobes and takes read data next cycle.
//
// Added by the designer: the address-and-strobe port and the placing of the registers.

`timescale 1ns/1ps

module tcc_timer
  import tcc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input logic ref_clk,
  input logic srst,
  input logic [TCC_ADDR_W-1:0] reg_addr,
  input logic [CNT_W-1:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [CNT_W-1:0] reg_rdata,
  input logic trigger_input_a,
  input logic trigger_input_b,
  output logic timer_output_pin,
  output logic match_irq_a,
  output logic match_irq_b
);

  ////////////////////////////////////////////////////////////////////////////
  // Software-visible state, prescaler count and trigger history
  logic [CNT_W-1:0] up_counter;
  logic [CNT_W-1:0] capture_compare_a;
  logic [CNT_W-1:0] capture_compare_b;
  tcc_run_mode_type run_mode;
  logic output_toggle_on_trigger;
  logic overflow_flag;
  logic [2:0] capture_select_reg;
  logic [6:0] prescaler_edge_reg;
  logic output_enable;
  logic [TCC_PRESC_W-1:0] presc_count;
  logic prev_a;
  logic prev_b;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  logic wr_count_a;
  logic wr_count_b;
  logic wr_mode;
  logic wr_capsel;
  logic wr_presc;
  logic wr_outctl;
  assign wr_count_a = reg_wr && (reg_addr == TCC_ADDR_CC_A);
  assign wr_count_b = reg_wr && (reg_addr == TCC_ADDR_CC_B);
  assign wr_mode = reg_wr && (reg_addr == TCC_ADDR_MODE);
  assign wr_capsel = reg_wr && (reg_addr == TCC_ADDR_CAPSEL);
  assign wr_presc = reg_wr && (reg_addr == TCC_ADDR_PRESC);
  assign wr_outctl = reg_wr && (reg_addr == TCC_ADDR_OUTCTL);

  // Configuration fields
  logic a_is_capture;
  logic b_is_capture;
  logic reverse_phase_select;
  logic [1:0] count_clock_select;
  logic [1:0] trigger_a_edge_select;
  logic [1:0] trigger_b_edge_select;
  assign a_is_capture = capture_select_reg[TCC_CAPSEL_A_CAP_BIT];
  assign b_is_capture = capture_select_reg[TCC_CAPSEL_B_CAP_BIT];
  assign reverse_phase_select = capture_select_reg[TCC_CAPSEL_REVERSE_BIT];
  assign count_clock_select = prescaler_edge_reg[TCC_PRESC_CLK_LO +: 2];
  assign trigger_a_edge_select = prescaler_edge_reg[TCC_PRESC_A_EDGE_LO +: 2];
  assign trigger_b_edge_select = prescaler_edge_reg[TCC_PRESC_B_EDGE_LO +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // Trigger edge detection
  logic rise_a;
  logic fall_a;
  logic rise_b;
  logic fall_b;
  logic valid_a;
  logic reverse_a;
  logic valid_b;
  assign rise_a = trigger_input_a && !prev_a;
  assign fall_a = !trigger_input_a && prev_a;
  assign rise_b = trigger_input_b && !prev_b;
  assign fall_b = !trigger_input_b && prev_b;

  // Edge select: 00 falling, 01 rising, 11 both, 10 never fires
  assign valid_a = ((trigger_a_edge_select == TCC_EDGE_FALL) && fall_a)
                || ((trigger_a_edge_select == TCC_EDGE_RISE) && rise_a)
                || ((trigger_a_edge_select == TCC_EDGE_BOTH) && (rise_a || fall_a));
  assign valid_b = ((trigger_b_edge_select == TCC_EDGE_FALL) && fall_b)
                || ((trigger_b_edge_select == TCC_EDGE_RISE) && rise_b)
                || ((trigger_b_edge_select == TCC_EDGE_BOTH) && (rise_b || fall_b));

  // Opposite phase of the trigger A valid edge; none when both edges count
  assign reverse_a = ((trigger_a_edge_select == TCC_EDGE_FALL) && rise_a)
                  || ((trigger_a_edge_select == TCC_EDGE_RISE) && fall_a);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prev_a <= 1'b0;
      prev_b <= 1'b0;
    end else begin
      prev_a <= trigger_input_a;
      prev_b <= trigger_input_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count clock from prescaler or trigger A
  logic count_tick;
  logic running;
  logic clear_mode;
  assign running = (run_mode == TCC_RUN_FREE) || (run_mode == TCC_RUN_CLEAR_START);
  assign clear_mode = (run_mode == TCC_RUN_CLEAR_START);
  assign count_tick = ((count_clock_select == TCC_CLK_DIV1))
                   || ((count_clock_select == TCC_CLK_DIV4) && (presc_count[1:0] == TCC_DIV4_LAST[1:0]))
                   || ((count_clock_select == TCC_CLK_DIV16) && (presc_count == TCC_DIV16_LAST))
                   || ((count_clock_select == TCC_CLK_TRIG_A) && valid_a);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      presc_count <= '0;
    end else begin
      presc_count <= presc_count + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare matches, captures and interrupt causes
  logic match_a;
  logic match_b;
  logic cap_a_now;
  logic cap_b_now;
  logic trig_clear;
  logic at_max;
  logic [CNT_W-1:0] cnt_plus_one;
  assign match_a = running && count_tick && !a_is_capture && (up_counter == capture_compare_a);
  assign match_b = running && count_tick && !b_is_capture && (up_counter == capture_compare_b);
  // A captures from the reverse phase of trigger A or from trigger B
  assign cap_a_now = running && a_is_capture && (reverse_phase_select ? reverse_a : valid_b);
  // B listens to trigger A only, so trigger B alone never fills it
  assign cap_b_now = running && b_is_capture && valid_a;
  assign trig_clear = clear_mode && valid_a;
  assign at_max = (up_counter == TCC_COUNT_MAX[CNT_W-1:0]);
  assign cnt_plus_one = up_counter + 1'b1;

  // Interrupt causes; reverse-phase captures are silent, trigger B still fires
  logic next_irq_a;
  logic next_irq_b;
  assign next_irq_a = match_a || (running && a_is_capture && valid_b);
  assign next_irq_b = match_b || cap_b_now;

  // Output toggle causes: any match, or trigger A when enabled
  logic toggle_req;
  assign toggle_req = match_a || match_b || (running && output_toggle_on_trigger && valid_a);

  ////////////////////////////////////////////////////////////////////////////
  // Counter and overflow
  logic [CNT_W-1:0] next_counter;
  logic ovf_set;
  logic ovf_clear;
  assign next_counter = !running ? TCC_RST_COUNT[CNT_W-1:0]
                      : trig_clear ? TCC_RST_COUNT[CNT_W-1:0]
                      : count_tick ? cnt_plus_one
                      : up_counter;
  assign ovf_set = running && count_tick && at_max && !trig_clear;
  assign ovf_clear = wr_mode && !reg_wdata[TCC_MODE_OVF_BIT];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      up_counter <= TCC_RST_COUNT[CNT_W-1:0];
    end else begin
      up_counter <= next_counter;
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      overflow_flag <= 1'b0;
    end else begin
      overflow_flag <= ovf_set || (overflow_flag && !ovf_clear);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture/compare registers; a capture beats a software write
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      capture_compare_a <= TCC_RST_CC[CNT_W-1:0];
    end else if (cap_a_now) begin
      capture_compare_a <= up_counter;
    end else if (wr_count_a) begin
      capture_compare_a <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      capture_compare_b <= TCC_RST_CC[CNT_W-1:0];
    end else if (cap_b_now) begin
      capture_compare_b <= up_counter;
    end else if (wr_count_b) begin
      capture_compare_b <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      run_mode <= TCC_RUN_STOP;
      output_toggle_on_trigger <= 1'b0;
    end else if (wr_mode) begin
      run_mode <= tcc_run_mode_type'(reg_wdata[TCC_MODE_RUN_LO +: 2]);
      output_toggle_on_trigger <= reg_wdata[TCC_MODE_TOGGLE_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      capture_select_reg <= TCC_RST_CAPSEL;
      prescaler_edge_reg <= TCC_RST_PRESC;
      output_enable <= 1'b0;
    end else begin
      if (wr_capsel) capture_select_reg <= reg_wdata[2:0];
      if (wr_presc) prescaler_edge_reg <= reg_wdata[6:0];
      if (wr_outctl) output_enable <= reg_wdata[TCC_OUTCTL_ENABLE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer output and interrupt pulses
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      timer_output_pin <= 1'b0;
      match_irq_a <= 1'b0;
      match_irq_b <= 1'b0;
    end else begin
      if (!output_enable) timer_output_pin <= 1'b0;
      else if (toggle_req) timer_output_pin <= !timer_output_pin;
      match_irq_a <= next_irq_a;
      match_irq_b <= next_irq_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; reading the counter has no side effect
  logic [CNT_W-1:0] rd_mux;
  logic [15:0] mode_word;
  assign mode_word = {12'h000, run_mode, output_toggle_on_trigger, overflow_flag};
  assign rd_mux = (reg_addr == TCC_ADDR_COUNTER) ? up_counter
                : (reg_addr == TCC_ADDR_CC_A) ? capture_compare_a
                : (reg_addr == TCC_ADDR_CC_B) ? capture_compare_b
                : (reg_addr == TCC_ADDR_MODE) ? mode_word[CNT_W-1:0]
                : (reg_addr == TCC_ADDR_CAPSEL) ? {{(CNT_W-3){1'b0}}, capture_select_reg}
                : (reg_addr == TCC_ADDR_PRESC) ? {{(CNT_W-7){1'b0}}, prescaler_edge_reg}
                : (reg_addr == TCC_ADDR_OUTCTL) ? {{(CNT_W-1){1'b0}}, output_enable}
                : '0;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_stop_zeroes:
  assert property (@(posedge ref_clk) disable iff (srst)
    (run_mode == TCC_RUN_STOP) |=> (up_counter == '0))
    else $error("counter not zero while stopped");

  a_free_increments:
  assert property (@(posedge ref_clk) disable iff (srst)
    (run_mode == TCC_RUN_FREE) && count_tick |=> (up_counter == $past(cnt_plus_one)))
    else $error("free-running counter did not step by one");

  a_wrap_overflow:
  assert property (@(posedge ref_clk) disable iff (srst)
    (run_mode == TCC_RUN_FREE) && count_tick && at_max |=> overflow_flag && (up_counter == '0))
    else $error("wrap did not set overflow");

  a_overflow_sticky:
  assert property (@(posedge ref_clk) disable iff (srst)
    overflow_flag && !ovf_clear |=> overflow_flag)
    else $error("overflow flag dropped without a clear");

  a_match_irq:
  assert property (@(posedge ref_clk) disable iff (srst)
    running && count_tick && !a_is_capture && (up_counter == capture_compare_a) && !trig_clear
    |=> match_irq_a && (up_counter == $past(cnt_plus_one)))
    else $error("compare A match missed or counter cleared");

  a_capture_b_trig:
  assert property (@(posedge ref_clk) disable iff (srst)
    running && b_is_capture && valid_a |=> match_irq_b && (capture_compare_b == $past(up_counter)))
    else $error("capture into B on trigger A failed");

  a_reverse_silent:
  assert property (@(posedge ref_clk) disable iff (srst)
    running && a_is_capture && reverse_phase_select && reverse_a && !valid_b
    |=> !match_irq_a && (capture_compare_a == $past(up_counter)))
    else $error("reverse-phase capture misbehaved");

  a_clear_start:
  assert property (@(posedge ref_clk) disable iff (srst)
    clear_mode && valid_a |=> (up_counter == '0))
    else $error("trigger A did not clear counter");

  a_trigger_toggle:
  assert property (@(posedge ref_clk) disable iff (srst)
    output_enable && running && output_toggle_on_trigger && valid_a
    |=> (timer_output_pin != $past(timer_output_pin)))
    else $error("output did not toggle on trigger A");

  a_counter_read:
  assert property (@(posedge ref_clk) disable iff (srst)
    reg_rd && (reg_addr == TCC_ADDR_COUNTER) |=> (reg_rdata == $past(up_counter)))
    else $error("counter read returned wrong value");

  a_prohibited_edge:
  assert property (@(posedge ref_clk) disable iff (srst)
    (trigger_b_edge_select == 2'h2) |-> !valid_b)
    else $error("prohibited edge select produced an edge");

  a_match_b_irq:
  assert property (@(posedge ref_clk) disable iff (srst)
    running && count_tick && !b_is_capture && (up_counter == capture_compare_b) && !trig_clear
    |=> match_irq_b && (up_counter == $past(cnt_plus_one)))
    else $error("compare B match missed or counter cleared");

  a_match_toggle:
  assert property (@(posedge ref_clk) disable iff (srst)
    output_enable && (match_a || match_b) |=> (timer_output_pin != $past(timer_output_pin)))
    else $error("output did not toggle on a compare match");

  a_trig_b_irq:
  assert property (@(posedge ref_clk) disable iff (srst)
    running && a_is_capture && reverse_phase_select && valid_b |=> match_irq_a)
    else $error("trigger B edge did not raise irq A");

  c_overflow_seen:
  cover property (@(posedge ref_clk) disable iff (srst) ovf_set);

  c_clear_start_capture:
  cover property (@(posedge ref_clk) disable iff (srst) clear_mode && cap_b_now);

  c_both_compare_toggle:
  cover property (@(posedge ref_clk) disable iff (srst) match_a ##[1:300] match_b);

  c_reverse_capture:
  cover property (@(posedge ref_clk) disable iff (srst) cap_a_now && reverse_phase_select);

endmodule : tcc_timer

//--- test/tb_top.sv
// Self-checking bench for the capture/compare timer: register master,
// compare, overflow and a table of capture cases with random preloads.
// Assumes tcc_pkg, tcc_timer and tcc_trig_model are compiled first.

`timescale 1ns/1ps

module tb_top
  import tcc_pkg::*;
();

  logic ref_clk, srst, reg_wr, reg_rd, req_a, req_b;
  logic [2:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d, va, vb;
  logic trigger_input_a, trigger_input_b, timer_output_pin, match_irq_a, match_irq_b;
  logic [7:0] irq_cnt_a, irq_cnt_b;
  logic [31:0] r;
  int seed;
  int error_cnt;
  int checked;

  ////////////////////////////////////////////////////////////////////////////
  // Design and far-side model
  tcc_timer tcc_timer_i (
    .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trigger_input_a(trigger_input_a), .trigger_input_b(trigger_input_b),
    .timer_output_pin(timer_output_pin), .match_irq_a(match_irq_a), .match_irq_b(match_irq_b)
  );
  tcc_trig_model tcc_trig_model_i (
    .ref_clk(ref_clk), .srst(srst), .req_a(req_a), .req_b(req_b),
    .match_irq_a(match_irq_a), .match_irq_b(match_irq_b),
    .trigger_input_a(trigger_input_a), .trigger_input_b(trigger_input_b),
    .irq_cnt_a(irq_cnt_a), .irq_cnt_b(irq_cnt_b)
  );

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and register port tasks
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Expected content of a capture register after one trigger step
  function automatic logic [15:0] exp_cap(input logic [1:0] cap, input logic [1:0] sel,
                                          input logic [15:0] cnt, input logic [15:0] pre);
    return (cap == sel) ? cnt : pre;
  endfunction : exp_cap

  task automatic test_done;
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    v = reg_rdata;
  endtask : rd

  // Bounded wait for an interrupt pulse, then check the output level
  task automatic wait_irq(input logic sel_b, input int lim, input logic pin);
    int n;
    n = 0;
    while (((sel_b ? match_irq_b : match_irq_a) !== 1'b1) && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= lim) begin
      chk("irq wait", 16'h0000, 16'h0001);
      test_done();
    end
    chk("pin level", {15'h0, timer_output_pin}, {15'h0, pin});
    @(posedge ref_clk);
  endtask : wait_irq

  // One trigger edge under a given setup; count clock /16 keeps the count still
  task automatic trig(input logic [7:0] m, c, p, input logic sb, lv, input logic [1:0] cap,
                      input logic dia, dib, tg);
    logic [15:0] c0, c1, pa, pb;
    logic [7:0] ia, ib;
    logic p0;
    r = $random(seed);
    pa = {1'b1, r[14:0]};
    pb = {1'b1, r[30:16]};
    wr(TCC_ADDR_CAPSEL, {8'h00, c});
    wr(TCC_ADDR_PRESC, {8'h00, p});
    wr(TCC_ADDR_MODE, {8'h00, m});
    wr(TCC_ADDR_CC_A, pa);
    wr(TCC_ADDR_CC_B, pb);
    rd(TCC_ADDR_COUNTER, c0);
    c1 = c0;
    for (int i = 0; i < 20 && c1 === c0; i++) begin
      rd(TCC_ADDR_COUNTER, c1);
    end
    if (c1 === c0) begin
      chk("count tick", c1, c0 + 16'h0001);
      test_done();
    end
    ia = irq_cnt_a;
    ib = irq_cnt_b;
    p0 = timer_output_pin;
    if (sb) begin
      req_b <= lv;
    end else begin
      req_a <= lv;
    end
    repeat (4) @(posedge ref_clk);
    rd(TCC_ADDR_COUNTER, c0);
    chk("count after", c0, (m[3] && cap == 2'h2) ? 16'h0000 : c1);
    rd(TCC_ADDR_CC_A, c0);
    chk("capture a", c0, exp_cap(cap, 2'h1, c1, pa));
    rd(TCC_ADDR_CC_B, c0);
    chk("capture b", c0, exp_cap(cap, 2'h2, c1, pb));
    chk("irq a count", {8'h00, irq_cnt_a - ia}, {15'h0, dia});
    chk("irq b count", {8'h00, irq_cnt_b - ib}, {15'h0, dib});
    if (!sb) begin
      chk("pin toggle", {15'h0, timer_output_pin ^ p0}, {15'h0, tg});
    end
  endtask : trig

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    srst = 1'b1;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    req_a = 1'b0;
    req_b = 1'b0;
    seed = 32'h2A9AD1B6;
    error_cnt = 0;
    checked = 0;
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    // Reset values, unmapped address, read-only counter
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), d);
      chk("reset value", d, 16'h0000);
    end
    wr(TCC_ADDR_COUNTER, 16'hFFFF);
    rd(TCC_ADDR_COUNTER, d);
    chk("counter read-only", d, 16'h0000);
    // Two compares in free-running mode
    r = $random(seed);
    va = {12'h004, r[3:0]};
    wr(TCC_ADDR_OUTCTL, 16'h0001);
    wr(TCC_ADDR_CC_A, va);
    wr(TCC_ADDR_CC_B, va + 16'h0020);
    wr(TCC_ADDR_MODE, 16'h0004);
    rd(TCC_ADDR_COUNTER, d);
    rd(TCC_ADDR_COUNTER, vb);
    chk("count step", vb - d, 16'h0002);
    wait_irq(1'b0, 200, 1'b1);
    rd(TCC_ADDR_COUNTER, d);
    chk("count kept", {15'h0, d > va}, 16'h0001);
    wait_irq(1'b1, 200, 1'b0);
    // Wrap past the top and the sticky overflow flag
    wr(TCC_ADDR_CC_A, 16'hFFFF);
    wait_irq(1'b0, 70000, 1'b1);
    rd(TCC_ADDR_COUNTER, d);
    chk("wrap", {15'h0, d < 16'h0008}, 16'h0001);
    rd(TCC_ADDR_MODE, d);
    chk("overflow set", d, 16'h0005);
    repeat (20) @(posedge ref_clk);
    rd(TCC_ADDR_MODE, d);
    chk("overflow held", d, 16'h0005);
    wr(TCC_ADDR_MODE, 16'h0004);
    rd(TCC_ADDR_MODE, d);
    chk("overflow cleared", d, 16'h0004);
    wr(TCC_ADDR_MODE, 16'h0000);
    rd(TCC_ADDR_COUNTER, d);
    chk("stopped", d, 16'h0000);
    // Capture table: mode, roles, edges, pin, level, target, irq a, irq b, toggle
    trig(8'h04, 8'h04, 8'h0A, 1'b0, 1'b1, 2'h2, 1'b0, 1'b1, 1'b0);
    trig(8'h04, 8'h04, 8'h0A, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0);
    trig(8'h04, 8'h05, 8'h7A, 1'b1, 1'b1, 2'h1, 1'b1, 1'b0, 1'b0);
    trig(8'h04, 8'h05, 8'h7A, 1'b1, 1'b0, 2'h1, 1'b1, 1'b0, 1'b0);
    trig(8'h06, 8'h05, 8'h5A, 1'b0, 1'b1, 2'h2, 1'b0, 1'b1, 1'b1);
    trig(8'h04, 8'h05, 8'h5A, 1'b0, 1'b0, 2'h2, 1'b0, 1'b1, 1'b0);
    trig(8'h04, 8'h05, 8'h72, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0);
    trig(8'h04, 8'h05, 8'h72, 1'b1, 1'b1, 2'h1, 1'b1, 1'b0, 1'b0);
    trig(8'h04, 8'h07, 8'h02, 1'b0, 1'b0, 2'h2, 1'b0, 1'b1, 1'b0);
    trig(8'h04, 8'h07, 8'h02, 1'b0, 1'b1, 2'h1, 1'b0, 1'b0, 1'b0);
    trig(8'h04, 8'h07, 8'h02, 1'b1, 1'b0, 2'h0, 1'b1, 1'b0, 1'b0);
    trig(8'h0A, 8'h04, 8'h0A, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0);
    trig(8'h0A, 8'h04, 8'h0A, 1'b0, 1'b1, 2'h2, 1'b0, 1'b1, 1'b1);
    trig(8'h08, 8'h05, 8'h6A, 1'b1, 1'b1, 2'h1, 1'b1, 1'b0, 1'b0);
    test_done();
  end

endmodule : tb_top

//--- test/tcc_trig_model.sv
// Trigger source and interrupt sink on the far side of the capture/compare timer.
// Assumes requests arrive from the bench just after ref_clk rising edges.

`timescale 1ns/1ps

module tcc_trig_model (
  input logic ref_clk,
  input logic srst,
  input logic req_a,
  input logic req_b,
  input logic match_irq_a,
  input logic match_irq_b,
  output logic trigger_input_a,
  output logic trigger_input_b,
  output logic [7:0] irq_cnt_a,
  output logic [7:0] irq_cnt_b
);

  ////////////////////////////////////////////////////////////////////////////
  // Trigger pins follow requests one clock late; reset holds them low
  always @(posedge ref_clk) begin
    trigger_input_a <= srst ? 1'b0 : req_a;
    trigger_input_b <= srst ? 1'b0 : req_b;
  end

  // Interrupt sink counts pulses; the timer output is never consulted
  always @(posedge ref_clk) begin
    if (srst) begin
      irq_cnt_a <= 8'h00;
      irq_cnt_b <= 8'h00;
    end else begin
      irq_cnt_a <= irq_cnt_a + {7'h00, match_irq_a};
      irq_cnt_b <= irq_cnt_b + {7'h00, match_irq_b};
    end
  end

endmodule : tcc_trig_model
